// >>> shared/tmwd_regs.vh
// Register map, field positions and constants of the timer control block
`ifndef TMWD_REGS_VH
`define TMWD_REGS_VH
// Byte offsets on the register bus
`define TMWD_OFF_GCTL    8'h00
`define TMWD_OFF_WDCTL   8'h04
`define TMWD_OFF_RELLO   8'h08
`define TMWD_OFF_RELHI   8'h0C
`define TMWD_OFF_CAPLO   8'h10
`define TMWD_OFF_PRDLO   8'h14
`define TMWD_OFF_PRDHI   8'h18
`define TMWD_OFF_CNTLO   8'h1C
`define TMWD_OFF_CNTHI   8'h20
`define TMWD_OFF_CTL     8'h24
`define TMWD_OFF_ISTAT   8'h28
`define TMWD_OFF_IMASK   8'h2C
// Global control fields
`define TMWD_LO_RUN      0
`define TMWD_HI_RUN      1
`define TMWD_CFG_LSB     2
`define TMWD_CFG_MSB     3
`define TMWD_PLUS_EN     4
// Configuration codes
`define TMWD_CFG_64      2'h0
`define TMWD_CFG_DUAL    2'h1
`define TMWD_CFG_WDOG    2'h2
`define TMWD_CFG_CHAIN   2'h3
// Watchdog control fields
`define TMWD_KEY_LSB     16
`define TMWD_KEY_MSB     31
`define TMWD_FLAG_BIT    15
`define TMWD_EN_BIT      14
`define TMWD_KEY_FIRST   16'hA5C6
`define TMWD_KEY_SECOND  16'hDA7E
// Control register: continuous run and capture mode per half
`define TMWD_CTL_CONT_LO 0
`define TMWD_CTL_CONT_HI 1
`define TMWD_CTL_CAP_LO  2
`define TMWD_CTL_CAP_HI  3
// Interrupt status bits
`define TMWD_IRQ_PRDLO   0
`define TMWD_IRQ_PRDHI   1
`define TMWD_IRQ_CAPLO   2
`define TMWD_IRQ_WDTO    3
`define TMWD_IRQ_W       4
`define TMWD_ZERO32      32'h0000_0000
`define TMWD_ONE32       32'h0000_0001
`define TMWD_ONES32      32'hFFFF_FFFF
`endif

// >>> hdl/tmwd_timer.v
// Timer and watchdog control with AHB-Lite register slave
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "tmwd_regs.vh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Select field picks dual, watchdog, chained
// - Select zero gives one 64-bit timer
// - Upper half held reset while run low and watchdog inactive
// - Lower half held reset while run low and watchdog inactive
// - Active watchdog freezes both run bits
// - Service needs first key then second
// - Keys do nothing outside watchdog mode
// - Timeout sets flag bit fifteen
// - Flag cleared by reset, enable, one
// - Bit fourteen enables watchdog, reset clears
// - Lower reload register, read write
// - Upper reload register, read write
// - Lower capture register holds counter copy
//////////////////////////////////////////////////////////////////////////////
module tmwd_timer (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        cap_evt_lo,
    input  wire        cap_evt_hi,
    output reg         wdog_rst_out,
    output reg         irq
);

    // Bus capture of the address phase
    reg        wr_pend_r;
    reg [7:0]  wr_addr_r;
    reg [31:0] gctl_r;
    reg [31:0] wdctl_r;
    reg [31:0] rel_lo_r;
    reg [31:0] rel_hi_r;
    reg [31:0] cap_lo_r;
    reg [31:0] cap_hi_r;
    reg [31:0] prd_lo_r;
    reg [31:0] prd_hi_r;
    reg [31:0] cnt_lo_r;
    reg [31:0] cnt_hi_r;
    reg [3:0]  ctl_r;
    reg [3:0]  istat_r;
    reg [3:0]  imask_r;
    reg        key_armed_r;
    reg        wd_active_r;

    wire       acc   = hsel & hready & htrans[1];
    wire       wr_go = wr_pend_r;
    wire [1:0] cfg   = gctl_r[`TMWD_CFG_MSB:`TMWD_CFG_LSB];
    wire [15:0] key  = hwdata[`TMWD_KEY_MSB:`TMWD_KEY_LSB];

    // Write strobe for a given offset in the data phase
    function wsel;
        input [7:0] a;
        begin
            wsel = wr_go && (wr_addr_r == a);
        end
    endfunction

    // Read data multiplexer, unmapped offsets read zero
    function [31:0] rmux;
        input [7:0] a;
        begin
            case (a)
                `TMWD_OFF_GCTL:  rmux = gctl_r;
                `TMWD_OFF_WDCTL: rmux = wdctl_r;
                `TMWD_OFF_RELLO: rmux = rel_lo_r;
                `TMWD_OFF_RELHI: rmux = rel_hi_r;
                `TMWD_OFF_CAPLO: rmux = cap_lo_r;
                `TMWD_OFF_PRDLO: rmux = prd_lo_r;
                `TMWD_OFF_PRDHI: rmux = prd_hi_r;
                `TMWD_OFF_CNTLO: rmux = cnt_lo_r;
                `TMWD_OFF_CNTHI: rmux = cnt_hi_r;
                `TMWD_OFF_CTL:   rmux = {28'h000_0000, ctl_r};
                `TMWD_OFF_ISTAT: rmux = {28'h000_0000, istat_r};
                `TMWD_OFF_IMASK: rmux = {28'h000_0000, imask_r};
                default:         rmux = `TMWD_ZERO32;
            endcase
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Counting engine
    // mode 64, watchdog and chained all carry lower into upper
    wire chain   = (cfg == `TMWD_CFG_64) || (cfg == `TMWD_CFG_CHAIN) ||
                   (cfg == `TMWD_CFG_WDOG);
    wire run_lo  = gctl_r[`TMWD_LO_RUN];
    wire run_hi  = gctl_r[`TMWD_HI_RUN];
    wire plus    = gctl_r[`TMWD_PLUS_EN];
    // Watchdog counts whenever active, whatever the run bits say
    wire en_lo   = run_lo | wd_active_r;
    wire en_hi   = run_hi | wd_active_r;
    wire mt_lo   = (cnt_lo_r == prd_lo_r);
    wire mt_hi   = (cnt_hi_r == prd_hi_r);
    wire mt_64   = mt_lo & mt_hi;
    // Half match events, chained halves match only as one 64-bit word
    wire ev_lo   = chain ? (en_lo & en_hi & mt_64) : (en_lo & mt_lo);
    wire ev_hi   = chain ? 1'b0 : (en_hi & mt_hi);
    // second key after first key, watchdog mode only
    wire key_wr  = wsel(`TMWD_OFF_WDCTL) && (cfg == `TMWD_CFG_WDOG);
    wire service = key_wr & key_armed_r & (key == `TMWD_KEY_SECOND);
    wire wd_to   = wd_active_r & ev_lo;

    // Counters, periods and capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_lo_r <= `TMWD_ZERO32;
            cnt_hi_r <= `TMWD_ZERO32;
            prd_lo_r <= `TMWD_ZERO32;
            prd_hi_r <= `TMWD_ZERO32;
            cap_lo_r <= `TMWD_ZERO32;
            cap_hi_r <= `TMWD_ZERO32;
        end else begin
            if (!en_lo || service || ev_lo)
                cnt_lo_r <= `TMWD_ZERO32;
            else if (!mt_lo || !chain)
                cnt_lo_r <= cnt_lo_r + `TMWD_ONE32;
            else
                cnt_lo_r <= `TMWD_ZERO32;
            if (!en_hi || service || ev_lo && chain || ev_hi)
                cnt_hi_r <= `TMWD_ZERO32;
            else if (!chain || (cnt_lo_r == `TMWD_ONES32) || mt_lo)
                cnt_hi_r <= cnt_hi_r + (chain ? `TMWD_ONE32 :
                                        `TMWD_ONE32);
            if (plus && ev_lo && !wsel(`TMWD_OFF_PRDLO))
                prd_lo_r <= rel_lo_r;
            else if (wsel(`TMWD_OFF_PRDLO))
                prd_lo_r <= hwdata;
            if (plus && (ev_hi || ev_lo && chain) &&
                !wsel(`TMWD_OFF_PRDHI))
                prd_hi_r <= rel_hi_r;
            else if (wsel(`TMWD_OFF_PRDHI))
                prd_hi_r <= hwdata;
            // capture on event, lower and upper capture registers
            if (ctl_r[`TMWD_CTL_CAP_LO] && cap_evt_lo && en_lo)
                cap_lo_r <= cnt_lo_r;
            else if (wsel(`TMWD_OFF_CAPLO))
                cap_lo_r <= hwdata;
            if (ctl_r[`TMWD_CTL_CAP_HI] && cap_evt_hi && en_hi)
                cap_hi_r <= cnt_hi_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Control registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gctl_r      <= `TMWD_ZERO32;
            wdctl_r     <= `TMWD_ZERO32;
            rel_lo_r    <= `TMWD_ZERO32;
            rel_hi_r    <= `TMWD_ZERO32;
            ctl_r       <= 4'h0;
            imask_r     <= 4'h0;
            key_armed_r <= 1'b0;
            wd_active_r <= 1'b0;
        end else begin
            if (wsel(`TMWD_OFF_GCTL)) begin
                gctl_r[`TMWD_CFG_MSB:`TMWD_CFG_LSB] <=
                    hwdata[`TMWD_CFG_MSB:`TMWD_CFG_LSB];
                gctl_r[`TMWD_PLUS_EN] <= hwdata[`TMWD_PLUS_EN];
                // run bits frozen when watchdog active
                if (!wd_active_r) begin
                    gctl_r[`TMWD_LO_RUN] <= hwdata[`TMWD_LO_RUN];
                    gctl_r[`TMWD_HI_RUN] <= hwdata[`TMWD_HI_RUN];
                end
            end
            // enable bit, clear flag on enable or write-one
            if (wsel(`TMWD_OFF_WDCTL)) begin
                wdctl_r[`TMWD_EN_BIT] <= hwdata[`TMWD_EN_BIT];
                if (hwdata[`TMWD_FLAG_BIT] ||
                    hwdata[`TMWD_EN_BIT] && !wdctl_r[`TMWD_EN_BIT])
                    wdctl_r[`TMWD_FLAG_BIT] <= 1'b0;
                wdctl_r[`TMWD_KEY_MSB:`TMWD_KEY_LSB] <= key;
            end
            // timeout sets flag, set wins over clear
            if (wd_to)
                wdctl_r[`TMWD_FLAG_BIT] <= 1'b1;
            // key sequence, only in watchdog mode
            if (key_wr)
                key_armed_r <= (key == `TMWD_KEY_FIRST);
            // Active once enabled with first key in watchdog mode
            if (key_wr && hwdata[`TMWD_EN_BIT] &&
                (key == `TMWD_KEY_FIRST))
                wd_active_r <= 1'b1;
            if (wsel(`TMWD_OFF_RELLO))
                rel_lo_r <= hwdata;
            if (wsel(`TMWD_OFF_RELHI))
                rel_hi_r <= hwdata;
            if (wsel(`TMWD_OFF_CTL))
                ctl_r <= hwdata[3:0];
            if (wsel(`TMWD_OFF_IMASK))
                imask_r <= hwdata[3:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, set beats clear
    wire [3:0] ev_vec = {wd_to, ctl_r[`TMWD_CTL_CAP_LO] & cap_evt_lo & en_lo,
                         ev_hi, ev_lo & ~wd_active_r};
    wire [3:0] clr_vec = wsel(`TMWD_OFF_ISTAT) ? hwdata[3:0] : 4'h0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_r      <= 4'h0;
            irq          <= 1'b0;
            wdog_rst_out <= 1'b0;
        end else begin
            istat_r      <= (istat_r & ~clr_vec) | ev_vec;
            irq          <= |(((istat_r & ~clr_vec) | ev_vec) & imask_r);
            wdog_rst_out <= wd_to;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= `TMWD_ZERO32;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= acc & hwrite;
            if (acc)
                wr_addr_r <= haddr[7:0];
            if (acc && !hwrite)
                hrdata <= rmux(haddr[7:0]);
        end
    end

endmodule // tmwd_timer

// >>> verif/tmwd_monitor.sv
// Port-level checks for the timer and watchdog register block
`timescale 1ns/100ps
`include "tmwd_regs.vh"
module tmwd_monitor (
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hwdata,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        cap_evt_lo,
    input logic        wdog_rst_out
);
    logic        dph_v_r, dph_w_r, wd_wr_r, cap_r, to_r;
    logic [7:0]  dph_a_r;
    logic [31:0] rel_lo_r, rel_hi_r;
    logic [1:0]  cfg_r;
    wire         wr_now = dph_v_r & dph_w_r & hready;
    wire         rd_now = dph_v_r & ~dph_w_r & hready;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    //////////////////////////////////////////////////////////////////////////
    // Shadow of software writes; reads are judged against it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {dph_v_r, dph_w_r, wd_wr_r, cap_r, to_r} <= 5'h00;
            dph_a_r <= 8'h00;
            rel_lo_r <= 32'h0000_0000;
            rel_hi_r <= 32'h0000_0000;
            cfg_r <= 2'h0;
        end else begin
            if (hready) begin
                dph_v_r <= hsel & htrans[1];
                dph_w_r <= hwrite;
                dph_a_r <= haddr[7:0];
            end
            if (wr_now && dph_a_r == `TMWD_OFF_RELLO) rel_lo_r <= hwdata;
            if (wr_now && dph_a_r == `TMWD_OFF_RELHI) rel_hi_r <= hwdata;
            if (wr_now && dph_a_r == `TMWD_OFF_GCTL) cfg_r <= hwdata[3:2];
            if (wr_now && dph_a_r == `TMWD_OFF_WDCTL) wd_wr_r <= 1'b1;
            // Any capture event or write makes the reset value moot
            if (cap_evt_lo || (wr_now && dph_a_r == `TMWD_OFF_CAPLO))
                cap_r <= 1'b1;
            // Timeout wins over a clearing write in the same cycle
            if (wdog_rst_out) to_r <= 1'b1;
            else if (wr_now && dph_a_r == `TMWD_OFF_WDCTL) to_r <= 1'b0;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    chk_ready_high: assert property (hreadyout)
        else $error("slave inserted a wait state");
    chk_pulse_single: assert property (wdog_rst_out |=> !wdog_rst_out)
        else $error("timeout pulse longer than one cycle");
    chk_pulse_wdog_cfg: assert property (wdog_rst_out |->
        wd_wr_r && cfg_r == `TMWD_CFG_WDOG)
        else $error("timeout outside watchdog configuration");
    chk_flag_held: assert property (rd_now && to_r &&
        dph_a_r == `TMWD_OFF_WDCTL |-> hrdata[`TMWD_FLAG_BIT])
        else $error("timeout flag not set after timeout");
    chk_rel_lo_back: assert property (rd_now &&
        dph_a_r == `TMWD_OFF_RELLO |-> hrdata == rel_lo_r)
        else $error("lower reload readback wrong");
    chk_rel_hi_back: assert property (rd_now &&
        dph_a_r == `TMWD_OFF_RELHI |-> hrdata == rel_hi_r)
        else $error("upper reload readback wrong");
    chk_wdog_en_reset: assert property (rd_now && !wd_wr_r &&
        dph_a_r == `TMWD_OFF_WDCTL |-> hrdata[15:14] == 2'b00)
        else $error("watchdog enable or flag not clear after reset");
    chk_cap_reset: assert property (rd_now && !cap_r &&
        dph_a_r == `TMWD_OFF_CAPLO |-> hrdata == 32'h0000_0000)
        else $error("capture register not zero after reset");
endmodule // tmwd_monitor

bind tmwd_timer tmwd_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .cap_evt_lo(cap_evt_lo),
    .wdog_rst_out(wdog_rst_out));

// >>> verif/tmwd_timer_tb.sv
// Self-checking bench for the timer and watchdog register block
`timescale 1ns/100ps
`include "tmwd_regs.vh"
module tmwd_timer_tb;
    logic        hclk, hresetn, hsel, hwrite, cap_evt_lo, cap_evt_hi, dph_rd;
    logic [31:0] haddr, hwdata, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, wdog_rst_out, irq;
    int          num_errors, n_compared, pcount, k;
    logic [63:0] expq[$];
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;

    tmwd_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cap_evt_lo(cap_evt_lo),
        .cap_evt_hi(cap_evt_hi), .wdog_rst_out(wdog_rst_out), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    //////////////////////////////////////////////////////////////////////////
    task end_of_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task cmp_rd(input logic [31:0] got);
        logic [63:0] e;
        n_compared++;
        e = (expq.size() > 0) ? expq.pop_front() : 64'h0;
        if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
            num_errors++;
            $display("[FAIL] %0t read %h expected %h", $time, got, e[31:0]);
        end
    endtask
    // One single transfer; a read notes its expectation under a mask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] m);
        int i;
        i = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        if (!w) expq.push_back({m, d});
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 64);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 64);
        if (i >= 64) begin num_errors++; end_of_test(); end
    endtask
    // Bounded wait for irq (which=1) or the timeout pulse to reach lvl
    task wait_lvl(input logic which, input logic lvl, input int n);
        k = 0;
        while ((which ? irq : wdog_rst_out) !== lvl && k < n) begin
            @(posedge hclk);
            k++;
        end
    endtask
    // Read data is taken at the edge that ends the data phase
    always @(posedge hclk) begin
        if (dph_rd && hreadyout === 1'b1) cmp_rd(hrdata);
        if (wdog_rst_out === 1'b1) pcount++;
        dph_rd <= hsel & htrans[1] & ~hwrite & hreadyout;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        end_of_test();
    end
    //////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, cap_evt_lo, cap_evt_hi, dph_rd} = 6'h00;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {num_errors, n_compared, pcount} = '0;
        v = $urandom(32'he74e);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, `TMWD_OFF_RELLO, 32'h0000_0000, ALL);
        bus(0, `TMWD_OFF_RELHI, 32'h0000_0000, ALL);
        bus(0, `TMWD_OFF_CAPLO, 32'h0000_0000, ALL);
        bus(0, `TMWD_OFF_WDCTL, 32'h0000_0000, 32'h0000_C000);
        v = $urandom;
        bus(1, `TMWD_OFF_RELLO, v, 32'h0);
        bus(1, `TMWD_OFF_RELHI, ~v, 32'h0);
        bus(0, `TMWD_OFF_RELLO, v, ALL);
        bus(0, `TMWD_OFF_RELHI, ~v, ALL);
        bus(0, 8'h3C, 32'h0000_0000, ALL);
        // Every configuration code, both halves released
        for (int c = 0; c < 4; c++) begin
            bus(1, `TMWD_OFF_GCTL, 32'h3 | (c << 2), 32'h0);
            bus(0, `TMWD_OFF_GCTL, 32'h3 | (c << 2), 32'h0000_000F);
        end
        // Capture event raises status; irq follows the mask only
        bus(1, `TMWD_OFF_CTL, 32'h0000_0004, 32'h0);
        cap_evt_lo <= 1'b1;
        cap_evt_hi <= $urandom;
        @(posedge hclk);
        cap_evt_lo <= 1'b0;
        wait_lvl(1, 1, 6);
        cmp_bit(k < 6, 1'b0);
        bus(1, `TMWD_OFF_IMASK, 32'h0000_0004, 32'h0);
        wait_lvl(1, 1, 6);
        cmp_bit(k < 6, 1'b1);
        bus(1, `TMWD_OFF_ISTAT, 32'h0000_0004, 32'h0);
        wait_lvl(1, 0, 6);
        cmp_bit(k < 6, 1'b1);
        // Watchdog: activate, service in order, then let it expire
        bus(1, `TMWD_OFF_PRDLO, 32'h0000_003C, 32'h0);
        bus(1, `TMWD_OFF_PRDHI, 32'h0000_0000, 32'h0);
        bus(1, `TMWD_OFF_GCTL, 32'h0000_000B, 32'h0);
        bus(1, `TMWD_OFF_WDCTL, 32'hA5C6_4000, 32'h0);
        repeat (5) begin
            bus(1, `TMWD_OFF_WDCTL, 32'hA5C6_4000, 32'h0);
            bus(1, `TMWD_OFF_WDCTL, 32'hDA7E_4000, 32'h0);
            repeat (10) @(posedge hclk);
        end
        cmp_bit(pcount == 0, 1'b1);
        bus(1, `TMWD_OFF_GCTL, 32'h0000_0008, 32'h0);
        bus(0, `TMWD_OFF_GCTL, 32'h0000_000B, 32'h0000_000F);
        wait_lvl(0, 1, 200);
        cmp_bit(k < 200, 1'b1);
        bus(0, `TMWD_OFF_WDCTL, 32'h0000_C000, 32'h0000_C000);
        bus(1, `TMWD_OFF_IMASK, 32'h0000_0008, 32'h0);
        wait_lvl(1, 1, 6);
        cmp_bit(k < 6, 1'b1);
        bus(1, `TMWD_OFF_WDCTL, 32'h0000_C000, 32'h0);
        bus(0, `TMWD_OFF_WDCTL, 32'h0000_4000, 32'h0000_C000);
        // Second reset: keys in plain 64-bit mode must not arm anything
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, `TMWD_OFF_WDCTL, 32'h0000_0000, 32'h0000_C000);
        bus(1, `TMWD_OFF_PRDLO, 32'h0000_0014, 32'h0);
        bus(1, `TMWD_OFF_GCTL, 32'h0000_0003, 32'h0);
        bus(1, `TMWD_OFF_WDCTL, 32'hA5C6_4000, 32'h0);
        bus(1, `TMWD_OFF_WDCTL, 32'hDA7E_4000, 32'h0);
        pcount = 0;
        repeat (100) @(posedge hclk);
        cmp_bit(pcount == 0, 1'b1);
        // Both halves held at zero while their run bits are low
        bus(1, `TMWD_OFF_GCTL, 32'h0000_0004, 32'h0);
        repeat (2) @(posedge hclk);
        bus(0, `TMWD_OFF_CNTLO, 32'h0000_0000, ALL);
        bus(0, `TMWD_OFF_CNTHI, 32'h0000_0000, ALL);
        // Enhanced mode loads the period from reload at the first match
        bus(1, `TMWD_OFF_RELLO, 32'h0000_0020, 32'h0);
        bus(1, `TMWD_OFF_PRDLO, 32'h0000_0005, 32'h0);
        bus(1, `TMWD_OFF_GCTL, 32'h0000_0015, 32'h0);
        repeat (20) @(posedge hclk);
        bus(0, `TMWD_OFF_PRDLO, 32'h0000_0020, ALL);
        end_of_test();
    end
endmodule // tmwd_timer_tb
